// ---- logic/recloser_pkg.sv ----
// shared constants, register map and types of the reclosing sequencer
package recloser_pkg;
	// timebase: every delay counts 5 ms steps of the system clock
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned STEP_NS       = 5000000;
	localparam int unsigned STEP_CYCLES   = STEP_NS / CLK_PERIOD_NS;
	// longest delay 1800 s in 5 ms steps
	localparam int unsigned MAX_DELAY_MS  = 1800000;
	localparam int unsigned STEP_MS       = 5;
	localparam int unsigned MAX_STEPS     = MAX_DELAY_MS / STEP_MS;
	localparam int unsigned TIM_W         = 19;

	localparam int unsigned N_REQ    = 5;
	localparam int unsigned N_SHOT   = 5;
	localparam int unsigned N_KIND   = 4;
	localparam int unsigned N_TIM    = N_REQ * N_SHOT * N_KIND;
	localparam int unsigned IDX_W    = 7;

	// delay kinds inside one shot's settings
	localparam logic [1:0] KIND_START   = 2'h0;
	localparam logic [1:0] KIND_DEAD    = 2'h1;
	localparam logic [1:0] KIND_ACTION  = 2'h2;
	localparam logic [1:0] KIND_RECLAIM = 2'h3;

	// register map, word addresses
	localparam logic [7:0] ADR_CTRL    = 8'h00;
	localparam logic [7:0] ADR_SHOT_EN = 8'h01;
	localparam logic [7:0] ADR_STATUS  = 8'h02;
	localparam logic [7:0] ADR_TIM     = 8'h40;
	localparam logic [7:0] ADR_TIM_END = 8'ha3;

	// control fields
	localparam int unsigned CTRL_ARC     = 0;
	localparam int unsigned CTRL_REFAULT = 1;
	localparam int unsigned CTRL_UNLOCK  = 2;
	localparam logic [1:0]  CTRL_RST     = 2'h0;
	localparam logic [24:0] SHOT_EN_RST  = 25'h0000000;
	localparam logic [TIM_W-1:0] TIM_RST = 19'h00000;

	typedef enum logic [8:0] {
		S_IDLE    = 9'h001,
		S_START   = 9'h002,
		S_ACTION  = 9'h004,
		S_DEAD    = 9'h008,
		S_CLOSE   = 9'h010,
		S_RECLAIM = 9'h020,
		S_FINAL   = 9'h040,
		S_LOCK    = 9'h080,
		S_OPENW   = 9'h100
	} seq_state_e;
endpackage

// ---- logic/step_timebase.sv ----
// free 5 ms step generator, restartable so a delay begins on a step edge
module step_timebase
	import recloser_pkg::*;
#(
	parameter int unsigned CYCLES = STEP_CYCLES
) (
	input  wire logic clk_sys, // system clock
	input  wire logic resetn,  // async reset, active low
	input  wire logic restart, // begin a fresh step
	output logic      tick     // one-cycle step pulse
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} tb_s;

	tb_s q, d;

	// count cycles; restart realigns so the first step is a whole step
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (restart) begin
			d.cnt = 32'h0;
		end else if (q.cnt >= CYCLES - 1) begin
			d.cnt = 32'h0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule

// ---- logic/delay_store.sv ----
// per request, per shot delay settings: bus port and lookup port
module delay_store
	import recloser_pkg::*;
(
	input  wire logic             clk_sys, // system clock
	input  wire logic             resetn,  // async reset, active low
	input  wire logic             wr_en,   // write one setting
	input  wire logic [IDX_W-1:0] wr_idx,  // setting written
	input  wire logic [TIM_W-1:0] wr_data, // new value in steps
	input  wire logic [IDX_W-1:0] rd_idx,  // setting read by the bus
	output logic      [TIM_W-1:0] rd_data, // registered bus read
	input  wire logic [IDX_W-1:0] lk_idx,  // setting used by sequence
	output logic      [TIM_W-1:0] lk_data  // current setting
);
	typedef struct packed {
		logic [N_TIM-1:0][TIM_W-1:0] tim;
		logic [TIM_W-1:0]            rd;
	} ds_s;

	ds_s q, d;

	// values above the 1800 s range are clamped on write
	always_comb begin
		d = q;
		d.rd = q.tim[rd_idx];
		if (wr_en) begin
			if (wr_data > TIM_W'(MAX_STEPS)) begin
				d.tim[wr_idx] = TIM_W'(MAX_STEPS);
			end else begin
				d.tim[wr_idx] = wr_data;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rd_data = q.rd;
	assign lk_data = q.tim[lk_idx];
endmodule

// ---- logic/auto_recloser_sequencer.sv ----
// reclosing sequencer: request priority, shot timers, close and lock-out
// Behaviour
// - Five reclose requests are ranked, the first highest, the fifth lowest.
// - The critical request ends any running sequence at once.
// - Once the breaker has opened, the dead time runs, then close is asked.
// - A failed shot moves to a further enabled shot or to final trip.
// - A setting picks an arcing delay or the protection's own timing.
// - A setting picks another shot or final trip on a refault in reclaim.
// - The first shot of a sequence has a starting delay of 0 to 1800 s in 5 ms steps.
// - Every shot has a dead time of 0 to 1800 s in 5 ms steps.
// - Every shot has an action time of 0 to 1800 s in 5 ms steps.
// - Every shot has a reclaim time that starts once the breaker closes.
// - A request during reclaim takes the next enabled shot or final trip.
// - Lock-out ends by reset input, software unlock or breaker close; close fail locks out.
module auto_recloser_sequencer
	import recloser_pkg::*;
#(
	parameter int unsigned STEP_CYC = STEP_CYCLES
) (
	input  wire logic        clk_sys,                         // clock
	input  wire logic        resetn,                          // reset, low
	input  wire logic        reclose_request_top_priority,    // request 1
	input  wire logic        reclose_request_2,               // request 2
	input  wire logic        reclose_request_3,               // request 3
	input  wire logic        reclose_request_4,               // request 4
	input  wire logic        reclose_request_lowest_priority, // request 5
	input  wire logic        critical_request,                // abort
	input  wire logic        breaker_closed,                  // status
	input  wire logic        close_fail,                      // close nack
	input  wire logic        lockout_reset,                   // unlock
	output logic             close_request,                   // to object
	output logic             final_trip,                      // pulse
	output logic             lockout,                         // locked
	output logic             ar_running,                      // busy
	output logic [N_SHOT-1:0] shot_running,                   // one-hot
	output logic [N_REQ-1:0] req_served,                      // one-hot
	input  wire logic [7:0]  bus_addr,                        // word addr
	input  wire logic [31:0] bus_wdata,                       // write data
	input  wire logic        bus_wr,                          // write
	input  wire logic        bus_rd,                          // read
	output logic      [31:0] bus_rdata                        // next cycle
);
	typedef struct packed {
		seq_state_e       st;
		logic [2:0]       req;
		logic [2:0]       shot;
		logic [TIM_W-1:0] cnt;
		logic [1:0]       ctrl;
		logic [24:0]      shot_en;
		logic             brk;
		logic             trip;
		logic             tim_sel;
		logic [31:0]      rdat;
	} seq_s;

	seq_s q, d;

	logic [N_REQ-1:0] req_v;
	logic             any_req;
	logic [2:0]       top_req;
	logic [3:0]       first_shot;
	logic [3:0]       next_shot;
	logic [1:0]       kind;
	logic [IDX_W-1:0] lk_idx;
	logic [TIM_W-1:0] lk_data;
	logic [TIM_W-1:0] tim_rdata;
	logic             tick;
	logic             expired;
	logic             tim_hit;
	logic             brk_rise;
	logic [IDX_W-1:0] bus_idx;

	// lowest set bit wins, so request 1 outranks the rest
	function automatic logic [2:0] pick_req(input logic [N_REQ-1:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = N_REQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// first enabled shot at or above 'from'; bit 3 flags that one exists
	function automatic logic [3:0] find_shot(input logic [N_SHOT-1:0] en,
	                                        input logic [2:0]        from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = N_SHOT - 1; i >= 0; i--) begin
			if (en[i] && 3'(i) >= from) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	assign req_v = {reclose_request_lowest_priority, reclose_request_4,
	                reclose_request_3, reclose_request_2,
	                reclose_request_top_priority};
	assign any_req = |req_v;
	assign top_req = pick_req(req_v);

	// shot search within the request's five enable bits
	assign first_shot = find_shot(q.shot_en[5*top_req +: 5], 3'h0);
	assign next_shot  = find_shot(q.shot_en[5*q.req +: 5],
	                              q.shot + 3'h1);

	// which delay of the shot is live depends on the sequence step
	always_comb begin
		kind = KIND_START;
		unique case (q.st)
			S_START:   kind = KIND_START;
			S_ACTION:  kind = KIND_ACTION;
			S_OPENW:   kind = KIND_ACTION;
			S_DEAD:    kind = KIND_DEAD;
			S_RECLAIM: kind = KIND_RECLAIM;
			default:   kind = KIND_START;
		endcase
	end

	// setting index: request first, then shot, then delay kind
	assign lk_idx  = IDX_W'(q.req) * IDX_W'(N_SHOT * N_KIND)
	               + IDX_W'(q.shot) * IDX_W'(N_KIND) + IDX_W'(kind);
	assign bus_idx = IDX_W'(bus_addr - ADR_TIM);
	assign tim_hit = bus_addr >= ADR_TIM && bus_addr <= ADR_TIM_END;
	assign expired = q.cnt >= lk_data;
	assign brk_rise = breaker_closed && !q.brk;

	// one store serves bus reads and the live lookup through separate ports
	delay_store u_store (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.wr_en   (bus_wr && tim_hit),
		.wr_idx  (bus_idx),
		.wr_data (bus_wdata[TIM_W-1:0]),
		.rd_idx  (bus_idx),
		.rd_data (tim_rdata),
		.lk_idx  (lk_idx),
		.lk_data (lk_data)
	);

	// restart on every state change so no delay starts on a partial step
	step_timebase #(
		.CYCLES (STEP_CYC)
	) u_step (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.restart (d.st != q.st),
		.tick    (tick)
	);

	// sequence, delay counter and register file
	always_comb begin
		d = q;
		d.trip = 1'b0;
		d.brk = breaker_closed;
		if (tick && q.cnt != TIM_W'(MAX_STEPS)) begin
			d.cnt = q.cnt + TIM_W'(1);
		end

		unique case (q.st)
			S_IDLE: begin
				// a request only starts a sequence on a closed breaker
				if (any_req && breaker_closed && first_shot[3]) begin
					d.st = S_START;
					d.req = top_req;
					d.shot = first_shot[2:0];
				end
			end
			S_START: begin
				// starting delay: request must hold for the whole delay
				if (!req_v[q.req]) begin
					d.st = S_IDLE;
				end else if (expired) begin
					d.st = q.ctrl[CTRL_ARC] ? S_ACTION : S_OPENW;
				end
			end
			S_ACTION: begin
				// arcing delay before the breaker is allowed to open
				if (expired) begin
					d.st = S_OPENW;
				end
			end
			S_OPENW: begin
				// protection opens the breaker; action time is the timeout when arcing delay is off
				if (!breaker_closed) begin
					d.st = S_DEAD;
				end else if (!q.ctrl[CTRL_ARC] && expired &&
				             !req_v[q.req]) begin
					d.st = S_IDLE;
				end
			end
			S_DEAD: begin
				// line de-energised; breaker left open for the dead time
				if (expired) begin
					d.st = S_CLOSE;
				end
			end
			S_CLOSE: begin
				// close asked until the object confirms or refuses
				if (breaker_closed) begin
					d.st = S_RECLAIM;
				end
			end
			S_RECLAIM: begin
				// a request here means the shot failed to clear the fault
				if (req_v[q.req] || any_req) begin
					if (!q.ctrl[CTRL_REFAULT] && next_shot[3]) begin
						d.st = S_OPENW;
						d.shot = next_shot[2:0];
					end else begin
						d.st = S_FINAL;
					end
				end else if (expired) begin
					d.st = S_IDLE;
				end
			end
			S_FINAL: begin
				// one-cycle trip pulse, then hold in lock-out
				d.trip = 1'b1;
				d.st = S_LOCK;
			end
			S_LOCK: begin
				// leave only by reset input, software unlock or a close
				if (lockout_reset || brk_rise ||
				    (bus_wr && bus_addr == ADR_CTRL &&
				     bus_wdata[CTRL_UNLOCK])) begin
					d.st = S_IDLE;
				end
			end
			default: d.st = S_LOCK;
		endcase

		// abort and close failure override any step of the sequence
		// critical first: a final trip outranks a plain lock-out
		if (q.st != S_IDLE && q.st != S_LOCK && q.st != S_FINAL) begin
			if (critical_request) begin
				d.st = S_FINAL;
			end else if (close_fail) begin
				d.st = S_LOCK;
			end
		end
		// a new state starts its delay from zero steps
		if (d.st != q.st) begin
			d.cnt = '0;
		end

		// register writes
		// unlock bit is a command only, so it is not stored
		if (bus_wr) begin
			if (bus_addr == ADR_CTRL) begin
				d.ctrl = bus_wdata[1:0];
			end
			if (bus_addr == ADR_SHOT_EN) begin
				d.shot_en = bus_wdata[24:0];
			end
		end

		// register reads, answered in the following cycle
		d.tim_sel = bus_rd && tim_hit;
		if (bus_rd) begin
			unique case (bus_addr)
				ADR_CTRL:    d.rdat = {30'h0, q.ctrl};
				ADR_SHOT_EN: d.rdat = {7'h0, q.shot_en};
				ADR_STATUS:  d.rdat = {13'h0, q.brk, q.shot, q.req,
				                      3'h0, q.st};
				default:     d.rdat = 32'h0;
			endcase
		end else begin
			d.rdat = 32'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q.st      <= S_IDLE;
			q.req     <= 3'h0;
			q.shot    <= 3'h0;
			q.cnt     <= TIM_RST;
			q.ctrl    <= CTRL_RST;
			q.shot_en <= SHOT_EN_RST;
			q.brk     <= 1'b0;
			q.trip    <= 1'b0;
			q.tim_sel <= 1'b0;
			q.rdat    <= 32'h0;
		end else begin
			q <= d;
		end
	end

	// outputs follow the state flops
	// final_trip is a flop, so it pulses in the first lock-out cycle
	assign close_request = q.st == S_CLOSE;
	assign final_trip    = q.trip;
	assign lockout       = q.st == S_LOCK;
	assign ar_running    = !(q.st inside {S_IDLE, S_LOCK, S_FINAL});
	assign shot_running  = ar_running ? N_SHOT'(5'h01 << q.shot) : '0;
	assign req_served    = ar_running ? N_REQ'(5'h01 << q.req) : '0;
	assign bus_rdata     = q.tim_sel ? {13'h0, tim_rdata} : q.rdat;
endmodule

// ---- tb/recloser_monitor.sv ----
// port checker of the reclosing sequencer
module recloser_monitor
	import recloser_pkg::*;
#(
	parameter int unsigned STEP_CYC = 4
) (
	input wire logic        clk_sys,          // clock
	input wire logic        resetn,           // reset, low
	input wire logic        critical_request, // abort
	input wire logic        breaker_closed,   // status
	input wire logic        close_fail,       // close nack
	input wire logic        lockout_reset,    // unlock
	input wire logic        close_request,    // close command
	input wire logic        final_trip,       // pulse
	input wire logic        lockout,          // locked
	input wire logic        ar_running,       // busy
	input wire logic [4:0]  shot_running,     // one-hot shot
	input wire logic [4:0]  req_served,       // one-hot request
	input wire logic [7:0]  bus_addr,         // word address
	input wire logic        bus_wr,           // write
	input wire logic        bus_rd,           // read
	input wire logic [31:0] bus_rdata         // read data
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_crit_final: assert property (
		ar_running && critical_request |=> ##1 final_trip)
		else $error("critical request did not trip");
	a_final_lock: assert property (
		$rose(final_trip) |-> ##1 lockout && !final_trip)
		else $error("final trip not followed by lock-out");
	a_fail_lock: assert property (
		ar_running && close_fail && !critical_request |=> lockout)
		else $error("close failure did not lock out");
	a_close_hold: assert property (
		close_request && !breaker_closed && !critical_request
		&& !close_fail |=> close_request)
		else $error("close request dropped early");
	a_close_drop: assert property (
		close_request && breaker_closed && !critical_request
		&& !close_fail |=> !close_request && ar_running)
		else $error("no reclaim after breaker closed");
	a_one_hot: assert property (
		ar_running |-> $onehot(shot_running) && $onehot(req_served))
		else $error("shot or request not one-hot");
	a_idle_clear: assert property (
		!ar_running |-> shot_running == 5'h00 && !close_request)
		else $error("shot or close active while idle");
	a_lock_hold: assert property (
		lockout && !lockout_reset && !breaker_closed
		&& !(bus_wr && bus_addr == ADR_CTRL) |=> lockout)
		else $error("lock-out left without cause");
	a_rd_idle: assert property (
		!bus_rd |=> bus_rdata == 32'h0)
		else $error("read data outside read slot");
endmodule

bind auto_recloser_sequencer recloser_monitor #(.STEP_CYC(STEP_CYC)) u_mon (
	.clk_sys, .resetn, .critical_request, .breaker_closed, .close_fail,
	.lockout_reset, .close_request, .final_trip, .lockout, .ar_running,
	.shot_running, .req_served, .bus_addr, .bus_wr, .bus_rd, .bus_rdata);

// ---- tb/breaker_object.sv ----
// breaker object model: closes after a lag, or acks a failure
module breaker_object (
	input  wire logic       clk_sys,        // clock
	input  wire logic       resetn,         // reset, low
	input  wire logic       close_request,  // close command
	input  wire logic       open_cmd,       // protection trip
	input  wire logic       fail_mode,      // answer with failure
	input  wire logic [3:0] lag,            // close lag in cycles
	output logic            breaker_closed, // status
	output logic            close_fail      // failure ack pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	// starts closed so a sequence may begin; a slow lag tests waiting
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			breaker_closed <= 1'b1;
			close_fail     <= 1'b0;
			cnt_q          <= 4'h0;
		end else begin
			close_fail <= 1'b0;
			cnt_q      <= close_request ? cnt_q + 4'h1 : 4'h0;
			if (open_cmd)
				breaker_closed <= 1'b0;
			else if (close_request && cnt_q == lag) begin
				close_fail     <= fail_mode;
				breaker_closed <= !fail_mode;
			end
		end
	end
endmodule

// ---- tb/test_auto_recloser_sequencer.sv ----
// self-checking bench of the reclosing sequencer
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_auto_recloser_sequencer
	import recloser_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, resetn, critical_request, lockout_reset;
	logic        bus_wr, bus_rd, open_cmd, fail_mode;
	logic        close_request, final_trip, lockout, ar_running;
	logic        breaker_closed, close_fail;
	logic [4:0]  req_in, shot_running, req_served, m;
	logic [7:0]  bus_addr;
	logic [31:0] bus_wdata, bus_rdata, rd_val;
	int          n_errors = 0, check_count = 0, waited, dead_n;
	int          seed = 99101;

	auto_recloser_sequencer #(.STEP_CYC(4)) u_auto_recloser_sequencer (
		.clk_sys, .resetn,
		.reclose_request_top_priority(req_in[0]),
		.reclose_request_2(req_in[1]), .reclose_request_3(req_in[2]),
		.reclose_request_4(req_in[3]),
		.reclose_request_lowest_priority(req_in[4]),
		.critical_request, .breaker_closed, .close_fail, .lockout_reset,
		.close_request, .final_trip, .lockout, .ar_running, .shot_running,
		.req_served, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
	breaker_object u_breaker_object (.clk_sys, .resetn, .close_request,
		.open_cmd, .fail_mode, .lag(4'h3), .breaker_closed, .close_fail);

	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// highest ranked request is the lowest set bit
	function automatic logic [4:0] top_req(input logic [4:0] r);
		return r & (~r + 5'h01);
	endfunction

	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		@(posedge clk_sys);
		rd_val = bus_rdata;
	endtask

	// k: 0 close, 1 lock-out, 2 final trip, 3 running; bounded wait
	task waitfor(input int k, input logic v);
		logic [3:0] o;
		check_count++;
		for (waited = 0; waited < 500; waited++) begin
			@(posedge clk_sys);
			o = {ar_running, final_trip, lockout, close_request};
			if (o[k] === v)
				return;
		end
		n_errors++;
		$display("mismatch wait %0d exp %b got timeout", k, v);
	endtask

	// protection trips the breaker, then drops its request
	task open_shot(input logic [4:0] r);
		req_in <= r;
		waitfor(3, 1'b1);
		open_cmd <= 1'b1;
		@(posedge clk_sys);
		open_cmd <= 1'b0;
		req_in   <= 5'h00;
	endtask

	task run_shot(input logic [4:0] r);
		open_shot(r);
		waitfor(0, 1'b1);
		dead_n = waited;
		waitfor(0, 1'b0);
	endtask

	task unlock;
		lockout_reset <= 1'b1;
		@(posedge clk_sys);
		lockout_reset <= 1'b0;
		waitfor(1, 1'b0);
	endtask

	// watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		$display("mismatch watchdog exp done got timeout");
		tally_and_finish;
	end

	// main sequence
	initial begin
		{req_in, critical_request, lockout_reset, bus_wr, bus_rd} = '0;
		{open_cmd, fail_mode, bus_addr, bus_wdata} = '0;
		resetn = 1'b0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(ADR_SHOT_EN);
		`CHK("shot_en", 32'h0, rd_val)
		rd(8'h10);
		`CHK("unmapped", 32'h0, rd_val)
		rd(ADR_STATUS);
		`CHK("status", 32'h00040001, rd_val)
		wr(ADR_TIM + 8'h01, 32'h0007ffff);
		rd(ADR_TIM + 8'h01);
		`CHK("clamp", 32'h00057e40, rd_val)
		wr(ADR_TIM + 8'h01, 32'h0);
		wr(ADR_TIM + 8'h15, 32'h3);
		wr(ADR_TIM + 8'h17, 32'h14);
		wr(ADR_TIM + 8'h1b, 32'h14);
		wr(ADR_SHOT_EN, 32'h00108461);
		// random request mixes, then a critical abort
		repeat (6) begin
			m = 5'($random(seed));
			if (m == 5'h00)
				m = 5'h10;
			req_in <= m;
			waitfor(3, 1'b1);
			`CHK("served", top_req(m), req_served)
			`CHK("shot", 5'h01, shot_running)
			critical_request <= 1'b1;
			waitfor(2, 1'b1);
			critical_request <= 1'b0;
			req_in           <= 5'h00;
			waitfor(1, 1'b1);
			unlock;
		end
		// two failed shots of request 2, the third fault trips finally
		run_shot(5'h02);
		`CHK("dead", 1'b1, dead_n >= 12 && dead_n <= 20)
		`CHK("reclaim", 1'b1, ar_running)
		run_shot(5'h02);
		`CHK("shot2", 5'h02, shot_running)
		req_in <= 5'h02;
		waitfor(2, 1'b1);
		req_in <= 5'h00;
		waitfor(1, 1'b1);
		wr(ADR_CTRL, 32'h4);
		waitfor(1, 1'b0);
		// refault lock-out set: a shot remains yet the trip is final
		wr(ADR_CTRL, 32'h2);
		run_shot(5'h02);
		req_in <= 5'h02;
		waitfor(2, 1'b1);
		req_in <= 5'h00;
		waitfor(1, 1'b1);
		unlock;
		// arcing delay: the action time now runs before the dead time starts
		wr(ADR_TIM + 8'h02, 32'h2);
		wr(ADR_CTRL, 32'h1);
		run_shot(5'h01);
		`CHK("arc", 1'b1, dead_n >= 8 && dead_n <= 14)
		wr(ADR_CTRL, 32'h0);
		// breaker refuses to close
		fail_mode <= 1'b1;
		open_shot(5'h01);
		waitfor(1, 1'b1);
		`CHK("fail_run", 1'b0, ar_running)
		fail_mode <= 1'b0;
		unlock;
		tally_and_finish;
	end
endmodule
